// File: logic/nlt_pkg.sv
/*
  Package for the listen-target controller: mode codes, response memory map, timing counts and carrier structs.
  Assumes a 10 MHz system clock; frames arrive and leave as bytes from an external framing block.
*/
// Behaviour
// R1 - Target-select bit high enters listen operation; mode field picks the variant.
// R2 - Mode top bit low runs fixed listen; low bits choose technology.
// R3 - NFC-A anticollision through SAK answered automatically; RATS and HLTA go to host.
// R4 - NFC-F answers polling request only if system code matches or is FFFFh.
// R5 - Type A state shown on outputs and wake flags; host sense/sleep commands force it.
// R6 - Type F wake flag set whenever a polling response was sent.
// R7 - All automatic reply bytes come from the response memory; the code sends the first polling reply byte as the constant POLL_HEAD.
// R8 - Active target with field detector turns on own field per response setting.
// R9 - Collision-avoidance count sets delay before own field turns on.
// R10 - Host sets general timer trigger to end of transmission; the code has no general timer.
// R11 - After field-on guard time raise collision-after-test or avoidance-complete flag.
// R12 - Mask receive timer starts at external field on; no-response timer adjustable.
// R13 - After own field off, wait for external field; timeout raises wait flag.
// R14 - Mode top bit high starts bit rate detection over allowed technologies.
// R15 - First frame start raises rate-identified flag and exposes the detected rate.
// R16 - Host leaves rate detection by writing the matching fixed listen mode.
// R17 - Active-frame filter drops active communication frames during rate detection.
// R18 - Low power detection needs enable, receive and transmit enables cleared.
// R19 - Field on raises field-on flag, wakes oscillator and receiver for 10 ms.
// R20 - Type A memory layout: identifier 0-9, sense reply 10-11, select replies 12-13.
// R21 - Type F layout: system code 15-16, polling reply 17-35, slot numbers 36-47.
// R22 - Polling reply starts 01h; last two bytes sent per request code.
// R23 - Reading the flag status clears it; interrupt drops when unmasked bits read.
// R24 - Slot numbers used in order, MSBs per slot count, low flag at four left.
package nlt_pkg;

  // ---------------------------------------------------------------
  // Memory map
  // ---------------------------------------------------------------
  localparam logic [5:0] MEM_UID = 6'h00;
  localparam logic [5:0] MEM_SENS = 6'h0A;
  localparam logic [5:0] MEM_SEL1 = 6'h0C;
  localparam logic [5:0] MEM_SEL2 = 6'h0D;
  localparam logic [5:0] MEM_SC = 6'h0F;
  localparam logic [5:0] MEM_POLL = 6'h11;
  localparam logic [5:0] MEM_POLL_LAST = 6'h23;
  localparam logic [5:0] MEM_TSN = 6'h24;
  localparam int MEM_DEPTH = 48;
  localparam logic [4:0] TSN_COUNT = 5'h18;
  localparam logic [4:0] TSN_LOW = 5'h04;
  localparam logic [7:0] POLL_HEAD = 8'h01;

  // ---------------------------------------------------------------
  // Frame codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_REQA = 8'h26;
  localparam logic [7:0] CMD_WUPA = 8'h52;
  localparam logic [7:0] CMD_SEL1 = 8'h93;
  localparam logic [7:0] CMD_SEL2 = 8'h95;
  localparam logic [7:0] CMD_HLTA = 8'h50;
  localparam logic [7:0] CMD_SENSF = 8'h00;
  localparam logic [7:0] NVB_FULL = 8'h70;
  localparam logic [15:0] SC_WILD = 16'hFFFF;
  localparam logic [7:0] RC_NONE = 8'h00;

  // ---------------------------------------------------------------
  // Mode field
  // ---------------------------------------------------------------
  localparam int OM_RATE_BIT = 3;
  localparam logic [2:0] OM_TYPEA = 3'h1;
  localparam logic [2:0] OM_TYPEF = 3'h4;
  localparam logic [2:0] OM_ACTIVE = 3'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int WAKE_HOLD_MS = 10;
  localparam int WAKE_HOLD_CYC = WAKE_HOLD_MS * (CLK_HZ / 1000);
  localparam int TICK_US = 1;
  localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  localparam int CA_UNIT_TICKS = 8;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } nlt_byte_t;

  typedef struct packed {
    logic field_on;
    logic typea_wake;
    logic typea_wake_star;
    logic typef_wake;
    logic slot_low;
    logic rate_found;
    logic guard_done_cat;
    logic guard_done_cac;
    logic wait_timeout;
  } nlt_flags_t;

  localparam int FLAG_W = 9;

  typedef enum logic [4:0] {
    TA_IDLE = 5'b00001,
    TA_READY = 5'b00010,
    TA_ACTIVE = 5'b00100,
    TA_SLEEP = 5'b01000,
    TA_READY2 = 5'b10000
  } nlt_tastate_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_SEND = 4'b0010,
    TX_CA = 4'b0100,
    TX_WAIT = 4'b1000
  } nlt_txstate_t;

endpackage : nlt_pkg

// File: logic/nlt_listen_ctrl.sv
/*
  Listen-target controller: automatic NFC-A and NFC-F replies, rate detection, active field timing, wake-up.
  Assumes a framing block supplies received bytes on the system clock and takes reply bytes one per strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module nlt_listen_ctrl
  import nlt_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_HOLD_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic target_sel_i,
  input wire logic [3:0] operating_mode_field_i,
  input wire logic [2:0] auto_response_field_sel_i,
  input wire logic [1:0] ca_count_i,
  input wire logic field_detector_enable_i,
  input wire logic active_frame_filter_i,
  input wire logic nrt_option_i,
  input wire logic [7:0] field_on_guard_time_i,
  input wire logic [7:0] response_field_wait_timer_i,
  input wire logic en_i,
  input wire logic rx_en_i,
  input wire logic tx_en_i,
  input wire logic ext_field_i,
  input wire logic own_tx_done_i,
  input wire logic collision_i,
  input wire nlt_byte_t rx_byte_i,
  input wire logic [1:0] rx_rate_i,
  input wire logic rx_active_frame_i,
  input wire logic tx_ready_i,
  input wire logic go_sense_i,
  input wire logic go_sleep_i,
  input wire logic mem_we_i,
  input wire logic [5:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic flag_read_i,
  input wire logic [FLAG_W-1:0] flag_mask_i,
  output logic [FLAG_W-1:0] flags_o,
  output logic irq_o,
  output nlt_byte_t tx_byte_o,
  output logic host_frame_o,
  output logic [4:0] typea_state_o,
  output logic [1:0] rate_o,
  output logic own_field_o,
  output logic mask_rx_o,
  output logic nrt_long_o,
  output logic wake_osc_o
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic field_meta;
  logic field_sync;
  logic field_prev;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      field_meta <= 1'b0;
      field_sync <= 1'b0;
      field_prev <= 1'b0;
    end
    else
    begin
      field_meta <= ext_field_i;
      field_sync <= field_meta;
      field_prev <= field_sync;
    end

  wire field_rise = field_sync & ~field_prev;

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire rate_mode = target_sel_i & operating_mode_field_i[OM_RATE_BIT]; // R14
  wire fixed_mode = target_sel_i & ~operating_mode_field_i[OM_RATE_BIT]; // R1 R2
  wire [2:0] om_low = operating_mode_field_i[2:0];
  wire typea_on = target_sel_i & om_low[0]; // R2 R14
  wire typef_on = target_sel_i & om_low[2];
  wire active_on = fixed_mode & om_low[1] & field_detector_enable_i; // R8
  // With the filter on, active frames are dropped throughout rate detection mode, before and after the rate is found.
  wire drop_frame = rate_mode & active_frame_filter_i & rx_active_frame_i; // R17
  wire rx_ok = rx_byte_i.valid & target_sel_i & ~drop_frame;

  // ---------------------------------------------------------------
  // Response memory
  // ---------------------------------------------------------------
  logic [7:0] response_memory [MEM_DEPTH];
  always_ff @(posedge sys_clk_i)
    if (mem_we_i)
      response_memory[mem_addr_i] <= mem_wdata_i; // R7

  // ---------------------------------------------------------------
  // Received frame capture
  // ---------------------------------------------------------------
  logic [4:0] rx_idx;
  logic [7:0] rx_cmd;
  logic [7:0] rx_nvb;
  logic [15:0] rx_sc;
  logic [7:0] rx_rc;
  logic [7:0] rx_tsl;
  logic rx_done;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      rx_idx <= 5'h00;
      rx_cmd <= 8'h00;
      rx_nvb <= 8'h00;
      rx_sc <= 16'h0000;
      rx_rc <= 8'h00;
      rx_tsl <= 8'h00;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= rx_ok & rx_byte_i.last;
      if (rx_ok)
      begin
        rx_idx <= rx_byte_i.first ? 5'h01 : rx_idx + 5'h01;
        if (rx_byte_i.first)
          rx_cmd <= rx_byte_i.data;
        if (rx_idx == 5'h01)
        begin
          rx_nvb <= rx_byte_i.data;
          rx_sc[15:8] <= rx_byte_i.data;
        end
        if (rx_idx == 5'h02)
          rx_sc[7:0] <= rx_byte_i.data;
        if (rx_idx == 5'h03)
          rx_rc <= rx_byte_i.data;
        if (rx_idx == 5'h04)
          rx_tsl <= rx_byte_i.data;
      end
    end

  // ---------------------------------------------------------------
  // Type A state
  // ---------------------------------------------------------------
  nlt_tastate_t ta_state;
  nlt_tastate_t next_ta_state;
  wire is_wake = (rx_cmd == CMD_WUPA);
  wire is_req = (rx_cmd == CMD_REQA) | is_wake;
  wire is_sel1 = (rx_cmd == CMD_SEL1);
  wire is_sel2 = (rx_cmd == CMD_SEL2);
  wire sel_full = (rx_nvb == NVB_FULL);
  wire fa = rx_done & typea_on;
  // RATS, HLTA and other frames are handed to the host unanswered.
  wire a_auto = fa & (is_req | is_sel1 | is_sel2); // R3
  wire f_match = (rx_sc == {response_memory[MEM_SC], response_memory[MEM_SC + 6'h01]}) | (rx_sc == SC_WILD);
  wire f_auto = rx_done & typef_on & (rx_cmd == CMD_SENSF) & f_match; // R4

  always_comb
  begin
    next_ta_state = ta_state;
    case (ta_state)
      TA_IDLE: if (fa & is_req) next_ta_state = TA_READY;
      TA_SLEEP: if (fa & is_wake) next_ta_state = TA_READY2;
      TA_READY, TA_READY2:
        if (fa & is_sel2 & sel_full) next_ta_state = TA_ACTIVE;
      TA_ACTIVE: if (fa & (rx_cmd == CMD_HLTA)) next_ta_state = TA_SLEEP;
      default: next_ta_state = TA_IDLE;
    endcase
    if (go_sense_i) next_ta_state = TA_IDLE; // R5
    if (go_sleep_i) next_ta_state = TA_SLEEP; // R5
    if (!typea_on) next_ta_state = TA_IDLE;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      ta_state <= TA_IDLE;
    else
      ta_state <= next_ta_state;

  // ---------------------------------------------------------------
  // Slot number queue
  // ---------------------------------------------------------------
  logic [4:0] tsn_used;
  wire [5:0] tsn_byte = MEM_TSN + {2'b00, tsn_used[4:1]};
  wire [7:0] tsn_pair = response_memory[tsn_byte];
  wire [3:0] tsn_raw = tsn_used[0] ? tsn_pair[3:0] : tsn_pair[7:4]; // R24
  logic [3:0] slot_mask;
  always_comb
  begin
    slot_mask = 4'hF;
    case (rx_tsl[3:0])
      4'h0: slot_mask = 4'h0;
      4'h1: slot_mask = 4'h8;
      4'h3: slot_mask = 4'hC;
      4'h7: slot_mask = 4'hE;
      default: slot_mask = 4'hF;
    endcase
  end
  wire [3:0] slot_num = tsn_raw & slot_mask; // R24

  // ---------------------------------------------------------------
  // Reply sender
  // ---------------------------------------------------------------
  nlt_txstate_t tx_state;
  logic [5:0] tx_addr;
  logic [5:0] tx_end;
  logic tx_poll;
  logic [4:0] tx_pos;
  wire tx_go = a_auto | f_auto;
  wire [5:0] a_start = is_req ? MEM_SENS : (sel_full ? (is_sel1 ? MEM_SEL1 : MEM_SEL2) : (is_sel1 ? MEM_UID : 6'h03)); // R20
  wire [5:0] a_end = is_req ? MEM_SENS + 6'h01 : (sel_full ? a_start : a_start + 6'h03);
  // Two trailing bytes hang on the request code.
  wire [5:0] f_end = (rx_rc == RC_NONE) ? MEM_POLL_LAST - 6'h02 : MEM_POLL_LAST; // R22
  wire [7:0] mem_byte = response_memory[tx_addr];
  wire [7:0] out_byte = (tx_poll & tx_pos == 5'h00) ? POLL_HEAD : mem_byte; // R22 R7
  wire tx_take = (tx_state == TX_SEND) & tx_ready_i;
  wire tx_last = (tx_addr == tx_end);

  // ---------------------------------------------------------------
  // Active target timing
  // ---------------------------------------------------------------
  logic [3:0] tick_cnt;
  wire tick = (tick_cnt == 4'(TICK_CYC - 1));
  logic [9:0] t_cnt;
  logic guard_run;
  logic [9:0] mrt_cnt;
  wire ca_done = (t_cnt == 10'(({8'h00, ca_count_i} + 10'h001) * CA_UNIT_TICKS)); // R9
  // The peer dropping its field opens the response collision avoidance window.
  wire start_ca = active_on & (auto_response_field_sel_i != 3'h0) & field_prev & ~field_sync; // R8

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      tick_cnt <= 4'h0;
    else
      tick_cnt <= tick ? 4'h0 : tick_cnt + 4'h1;

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      tx_state <= TX_IDLE;
      tx_addr <= 6'h00;
      tx_end <= 6'h00;
      tx_poll <= 1'b0;
      tx_pos <= 5'h00;
      tsn_used <= 5'h00;
      t_cnt <= 10'h000;
      guard_run <= 1'b0;
      own_field_o <= 1'b0;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
          if (tx_go)
          begin
            tx_state <= TX_SEND;
            tx_poll <= f_auto;
            tx_pos <= 5'h00;
            tx_addr <= f_auto ? MEM_POLL : a_start; // R21
            tx_end <= f_auto ? f_end : a_end;
            if (f_auto & tsn_used != TSN_COUNT)
              tsn_used <= tsn_used + 5'h01; // R24
          end
          else if (start_ca)
          begin
            tx_state <= TX_CA;
            t_cnt <= 10'h000;
          end
        TX_SEND:
          if (tx_take)
          begin
            tx_pos <= tx_pos + 5'h01;
            tx_addr <= tx_addr + 6'h01;
            if (tx_last)
              tx_state <= TX_IDLE;
          end
        TX_CA:
          if (tick)
          begin
            t_cnt <= t_cnt + 10'h001;
            if (ca_done)
            begin
              own_field_o <= 1'b1; // R8
              guard_run <= 1'b1;
              t_cnt <= 10'h000;
              tx_state <= TX_IDLE;
            end
          end
        TX_WAIT:
          if (field_sync)
            tx_state <= TX_IDLE;
          else if (tick)
          begin
            t_cnt <= t_cnt + 10'h001;
            if (t_cnt[7:0] == response_field_wait_timer_i)
              tx_state <= TX_IDLE; // R13
          end
        default: tx_state <= TX_IDLE;
      endcase
      if (guard_run & tick & tx_state == TX_IDLE)
      begin
        t_cnt <= t_cnt + 10'h001;
        if (t_cnt[7:0] == field_on_guard_time_i)
          guard_run <= 1'b0; // R11
      end
      if (own_field_o & own_tx_done_i & tx_state == TX_IDLE & !guard_run)
      begin
        own_field_o <= 1'b0;
        tx_state <= TX_WAIT; // R13
        t_cnt <= 10'h000;
      end
      if (!active_on)
        own_field_o <= 1'b0;
    end

  wire guard_end = guard_run & tick & tx_state == TX_IDLE & (t_cnt[7:0] == field_on_guard_time_i);
  wire wait_end = (tx_state == TX_WAIT) & ~field_sync & tick & (t_cnt[7:0] == response_field_wait_timer_i);

  // ---------------------------------------------------------------
  // Mask receive, rate detect and wake-up
  // ---------------------------------------------------------------
  logic rate_seen;
  logic [23:0] wake_cnt;
  wire low_power = ~en_i & ~rx_en_i & ~tx_en_i & target_sel_i; // R18
  wire rate_hit = rate_mode & rx_ok & rx_byte_i.first & ~rate_seen; // R15
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      mrt_cnt <= 10'h000;
      rate_seen <= 1'b0;
      rate_o <= 2'b00;
      wake_cnt <= 24'h00_0000;
      wake_osc_o <= 1'b0;
      mask_rx_o <= 1'b0;
      nrt_long_o <= 1'b0;
      host_frame_o <= 1'b0;
      typea_state_o <= TA_IDLE;
    end
    else
    begin
      nrt_long_o <= nrt_option_i; // R12
      typea_state_o <= ta_state; // R5
      host_frame_o <= rx_done & ~a_auto & ~f_auto; // R3
      if (field_rise & active_on)
        mrt_cnt <= 10'h000; // R12
      else if (tick & mrt_cnt != 10'h3FF)
        mrt_cnt <= mrt_cnt + 10'h001;
      mask_rx_o <= active_on & (mrt_cnt != 10'h3FF);
      if (!rate_mode)
        rate_seen <= 1'b0; // R16
      else if (rate_hit)
      begin
        rate_seen <= 1'b1;
        rate_o <= rx_rate_i; // R15
      end
      if (field_rise & low_power)
      begin
        wake_osc_o <= 1'b1; // R19
        wake_cnt <= 24'(WAKE_CYCLES);
      end
      else if (en_i & rx_en_i)
        wake_osc_o <= 1'b0;
      else if (wake_cnt != 24'h00_0000)
        wake_cnt <= wake_cnt - 24'h00_0001;
      else
        wake_osc_o <= 1'b0;
    end

  // ---------------------------------------------------------------
  // Flags and interrupt
  // ---------------------------------------------------------------
  nlt_flags_t ev;
  always_comb
  begin
    ev.field_on = field_rise; // R19
    ev.typea_wake = fa & is_req & ta_state == TA_IDLE; // R5
    ev.typea_wake_star = fa & is_wake & ta_state == TA_SLEEP; // R5
    ev.typef_wake = f_auto; // R6
    ev.slot_low = f_auto & (tsn_used == TSN_COUNT - TSN_LOW - 5'h01); // R24
    ev.rate_found = rate_hit; // R15
    ev.guard_done_cat = guard_end & collision_i; // R11
    ev.guard_done_cac = guard_end & ~collision_i; // R11
    ev.wait_timeout = wait_end; // R13
  end

  // A new event in the clearing cycle survives the read.
  wire [FLAG_W-1:0] next_flags = (flag_read_i ? {FLAG_W{1'b0}} : flags_o) | ev; // R23
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      flags_o <= {FLAG_W{1'b0}};
      irq_o <= 1'b0;
    end
    else
    begin
      flags_o <= next_flags;
      irq_o <= |(next_flags & ~flag_mask_i); // R23
    end

  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      tx_byte_o <= '0;
    else
    begin
      tx_byte_o.valid <= tx_take;
      tx_byte_o.first <= tx_take & (tx_pos == 5'h00);
      tx_byte_o.last <= tx_take & tx_last;
      tx_byte_o.data <= tx_take ? out_byte : 8'h00;
    end

endmodule : nlt_listen_ctrl
`default_nettype wire

// File: tb/nlt_listen_ctrl_sva.sv
/*
  Port checker for the listen-target controller.
  Assumes it is bound onto nlt_listen_ctrl and sees its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module nlt_listen_ctrl_sva
  import nlt_pkg::*;
#(
  parameter int WAKE_CYCLES = 50
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic target_sel_i,
  input wire logic [3:0] operating_mode_field_i,
  input wire logic [2:0] auto_response_field_sel_i,
  input wire logic field_detector_enable_i,
  input wire logic en_i,
  input wire logic rx_en_i,
  input wire logic ext_field_i,
  input wire logic flag_read_i,
  input wire logic [FLAG_W-1:0] flag_mask_i,
  input wire logic [FLAG_W-1:0] flags_o,
  input wire logic irq_o,
  input wire nlt_byte_t tx_byte_o,
  input wire logic [4:0] typea_state_o,
  input wire logic own_field_o,
  input wire logic wake_osc_o
);
  // An unconfirmed wake-up must end on its own, or the part never returns to low power.
  logic [31:0] wake_cnt;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      wake_cnt <= 32'h0000_0000;
    else if (wake_osc_o && !(en_i && rx_en_i))
      wake_cnt <= wake_cnt + 32'h0000_0001;
    else
      wake_cnt <= 32'h0000_0000;
  end
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  reset_values_a: assert property ($fell(rst_i) |-> typea_state_o == TA_IDLE && flags_o == 9'h000)
    else $error("bad state after reset");
  state_onehot_a: assert property ($onehot(typea_state_o))
    else $error("type A state not one-hot");
  flags_sticky_a: assert property ((|($past(flags_o) & ~flags_o)) |-> $past(flag_read_i))
    else $error("flag dropped without read");
  read_clears_a: assert property (flag_read_i |=> (flags_o & $past(flags_o)) == 9'h000)
    else $error("flag survived read");
  irq_cause_a: assert property (irq_o |-> (|(flags_o & ~flag_mask_i)) || (|($past(flags_o) & ~$past(flag_mask_i))))
    else $error("irq without unmasked flag");
  tx_listen_a: assert property (tx_byte_o.valid |-> target_sel_i)
    else $error("reply outside listen mode");
  rate_mode_a: assert property ($rose(flags_o[3]) |-> operating_mode_field_i[3])
    else $error("rate flag outside rate mode");
  field_on_a: assert property ($rose(flags_o[8]) |-> $past(ext_field_i, 2))
    else $error("field-on flag without field");
  own_gate_a: assert property (own_field_o |-> field_detector_enable_i && auto_response_field_sel_i != 3'h0)
    else $error("own field without enables");
  wake_bound_a: assert property (wake_cnt <= WAKE_CYCLES + 4)
    else $error("wake-up held too long");
  cover property (tx_byte_o.valid && tx_byte_o.first);
  cover property ($rose(flags_o[0]));
  cover property ($rose(flags_o[3]));
endmodule : nlt_listen_ctrl_sva
bind nlt_listen_ctrl nlt_listen_ctrl_sva #(.WAKE_CYCLES(WAKE_CYCLES)) i_sva (.*);
`default_nettype wire

// File: tb/nlt_reader_model.sv
/*
  Remote reader model: sends request frames byte by byte and gathers reply bytes.
  Assumes the bench calls send and reads got; one shared system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nlt_reader_model
  import nlt_pkg::*;
(
  input wire logic clk_i,
  input wire nlt_byte_t tx_byte_i,
  input wire logic slow_i,
  output nlt_byte_t rx_byte_o,
  output logic tx_ready_o
);
  logic [7:0] got[$];
  initial
  begin
    rx_byte_o = '0;
    tx_ready_o = 1'b1;
  end
  // A slow reader stalls every other cycle to exercise the reply handshake.
  always @(negedge clk_i)
    tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
  always @(posedge clk_i)
    if (tx_byte_i.valid === 1'b1)
      got.push_back(tx_byte_i.data);
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++)
    begin
      @(negedge clk_i);
      rx_byte_o <= {1'b1, i == 0, i == b.size() - 1, b[i]};
    end
    @(negedge clk_i);
    rx_byte_o <= {3'b000, ~rx_byte_o.data};
  endtask : send
endmodule : nlt_reader_model
`default_nettype wire

// File: tb/nlt_listen_ctrl_tb.sv
/*
  Bench for the listen-target controller: replies, states, rate detection, active field, wake-up.
  Assumes the reader model on the byte side; the bench plays the host.
*/
`timescale 1ns/1ps
`default_nettype none
module nlt_listen_ctrl_tb;
  import nlt_pkg::*;
  localparam int WK = 50;
  logic sys_clk_i, rst_i, target_sel_i, field_detector_enable_i, active_frame_filter_i, nrt_option_i;
  logic en_i, rx_en_i, tx_en_i, ext_field_i, own_tx_done_i, collision_i, rx_active_frame_i, slow;
  logic go_sense_i, go_sleep_i, mem_we_i, flag_read_i, irq_o, host_frame_o, own_field_o;
  logic mask_rx_o, nrt_long_o, wake_osc_o, tx_ready_i;
  logic [3:0] operating_mode_field_i;
  logic [2:0] auto_response_field_sel_i;
  logic [1:0] ca_count_i, rx_rate_i, rate_o;
  logic [7:0] field_on_guard_time_i, response_field_wait_timer_i, mem_wdata_i;
  logic [5:0] mem_addr_i;
  logic [8:0] flag_mask_i, flags_o;
  logic [4:0] typea_state_o;
  nlt_byte_t rx_byte_i, tx_byte_o;
  logic [7:0] mem[MEM_DEPTH];
  int failures = 0, n_compared = 0, n_host = 0;
  wire logic [12:0] obs = {~wake_osc_o, wake_osc_o, own_field_o, irq_o, flags_o};
  nlt_listen_ctrl #(.WAKE_CYCLES(WK)) i_dut (.*);
  nlt_reader_model i_rdr (.clk_i(sys_clk_i), .tx_byte_i(tx_byte_o), .slow_i(slow), .rx_byte_o(rx_byte_i),
    .tx_ready_o(tx_ready_i));
  initial
  begin
    sys_clk_i = 1'b0;
    forever
      #50 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
    if (host_frame_o === 1'b1)
      n_host++;
  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick
  task automatic do_reset;
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
  endtask : do_reset
  task automatic wait_for(input int idx, input int lim);
    for (int n = 0; n < lim && obs[idx] !== 1'b1; n++)
      tick(1);
    chk(obs[idx], 1'b1);
  endtask : wait_for
  task automatic mw(input int a, input logic [7:0] d);
    mem[a] = d;
    tick(1);
    mem_we_i = 1'b1;
    mem_addr_i = 6'(a);
    mem_wdata_i = d;
    tick(1);
    mem_we_i = 1'b0;
  endtask : mw
  task automatic load;
    for (int i = 0; i < MEM_DEPTH; i++)
      mw(i, (i == MEM_POLL) ? POLL_HEAD : 8'hA0 ^ 8'(i));
  endtask : load
  task automatic rd;
    flag_read_i = 1'b1;
    tick(1);
    flag_read_i = 1'b0;
    tick(2);
  endtask : rd
  // Replies are compared byte for byte with the shadow of the response memory.
  task automatic req(input logic [7:0] b[$], input int a, input int n);
    i_rdr.got.delete();
    i_rdr.send(b);
    tick(120);
    chk(i_rdr.got.size(), n);
    for (int k = 0; k < n && k < i_rdr.got.size(); k++)
      chk(i_rdr.got[k], mem[a + k]);
  endtask : req
  initial
  begin
    {target_sel_i, field_detector_enable_i, active_frame_filter_i, nrt_option_i, ext_field_i} = '0;
    {own_tx_done_i, collision_i, rx_active_frame_i, go_sense_i, go_sleep_i, mem_we_i, flag_read_i, slow} = '0;
    {en_i, rx_en_i, tx_en_i, rst_i} = 4'hF;
    {operating_mode_field_i, auto_response_field_sel_i, ca_count_i, rx_rate_i} = '0;
    {field_on_guard_time_i, response_field_wait_timer_i, mem_wdata_i, mem_addr_i, flag_mask_i} = '0;
    tick(2);
    rst_i = 1'b0;
    chk(typea_state_o, TA_IDLE);
    chk(flags_o, 9'h000);
    target_sel_i = 1'b1;
    operating_mode_field_i = 4'b0100;
    load();
    for (int i = 0; i < 19; i++)
      req({CMD_SENSF, 8'hFF, 8'hFF, RC_NONE, 8'h00}, MEM_POLL, 17);
    chk(flags_o[4], 1'b0);
    req({CMD_SENSF, mem[15], mem[16], 8'h01, 8'h00}, MEM_POLL, 19);
    chk(flags_o[4], 1'b1);
    chk(flags_o[5], 1'b1);
    rd();
    chk(flags_o, 9'h000);
    req({CMD_SENSF, mem[15], ~mem[16], 8'h01, 8'h00}, 0, 0);
    chk(flags_o[5], 1'b0);
    mw(MEM_POLL + 1, 8'h5C);
    slow = 1'b1;
    req({CMD_SENSF, 8'hFF, 8'hFF, 8'h01, 8'h00}, MEM_POLL, 19);
    slow = 1'b0;
    do_reset();
    operating_mode_field_i = 4'b0001;
    load();
    n_host = 0;
    req({CMD_REQA}, MEM_SENS, 2);
    chk(typea_state_o, TA_READY);
    chk(|flags_o[7:6], 1'b1);
    req({CMD_SEL2, NVB_FULL, mem[0], mem[1], mem[2], mem[3], mem[0] ^ mem[1] ^ mem[2] ^ mem[3]}, MEM_SEL2, 1);
    chk(typea_state_o, TA_ACTIVE);
    req({CMD_HLTA, 8'h00}, 0, 0);
    chk(n_host, 1);
    go_sleep_i = 1'b1;
    tick(1);
    go_sleep_i = 1'b0;
    tick(2);
    chk(typea_state_o, TA_SLEEP);
    go_sense_i = 1'b1;
    tick(1);
    go_sense_i = 1'b0;
    tick(2);
    chk(typea_state_o, TA_IDLE);
    do_reset();
    operating_mode_field_i = 4'b1101;
    flag_mask_i = 9'h1FF;
    rx_rate_i = 2'b10;
    {active_frame_filter_i, rx_active_frame_i} = 2'b11;
    i_rdr.send({CMD_HLTA, 8'h00});
    tick(4);
    chk(flags_o[3], 1'b0);
    rx_active_frame_i = 1'b0;
    i_rdr.send({CMD_HLTA, 8'h00});
    tick(4);
    chk(flags_o[3], 1'b1);
    chk(rate_o, 2'b10);
    chk(irq_o, 1'b0);
    flag_mask_i = 9'h000;
    tick(2);
    chk(irq_o, 1'b1);
    rd();
    chk(irq_o, 1'b0);
    operating_mode_field_i = 4'b0001;
    do_reset();
    operating_mode_field_i = 4'b0010;
    {field_detector_enable_i, nrt_option_i} = 2'b11;
    auto_response_field_sel_i = 3'h1;
    field_on_guard_time_i = 8'h05;
    response_field_wait_timer_i = 8'h05;
    ext_field_i = 1'b1;
    wait_for(8, 20);
    chk(mask_rx_o, 1'b1);
    chk(nrt_long_o, 1'b1);
    ext_field_i = 1'b0;
    wait_for(10, 3000);
    wait_for(1, 3000);
    own_tx_done_i = 1'b1;
    tick(1);
    own_tx_done_i = 1'b0;
    wait_for(0, 3000);
    do_reset();
    {en_i, rx_en_i, tx_en_i} = 3'b000;
    operating_mode_field_i = 4'b0001;
    ext_field_i = 1'b1;
    wait_for(11, 20);
    chk(flags_o[8], 1'b1);
    wait_for(12, WK + 20);
    tally_and_finish();
  end
  initial
  begin
    repeat (30000) @(posedge sys_clk_i);
    failures++;
    tally_and_finish();
  end
endmodule : nlt_listen_ctrl_tb
`default_nettype wire
